/* File: logic/raro_regs.svh */
// raro_regs.svh: opcode patterns, field positions and reset values
// assumes 10-bit instruction words and a 4-bit data path
`ifndef RARO_REGS_SVH
`define RARO_REGS_SVH

// widths
`define RARO_OPC_W       10
`define RARO_NIB_W       4
`define RARO_BANK_W      2
`define RARO_DRV_W       3
`define RARO_BYTE_W      8

// immediate field positions inside the instruction word, then byte buffer and acc fields
`define RARO_FILE_IMM    7:4
`define RARO_WORD_IMM    3:0
`define RARO_BANK_IMM    1:0
`define RARO_XOR_IMM     3:0
`define RARO_BYTE_HI     7:4
`define RARO_BYTE_LO     3:0
`define RARO_ACC_DRV     2:0
`define RARO_ACC_BANK    1:0

// masks and patterns
`define RARO_MASK_FULL   10'h3FF
`define RARO_MASK_FW     10'h300
`define RARO_MASK_BANK   10'h3FC
`define RARO_MASK_XOR    10'h3F0

`define RARO_OPC_COPY_STACK_DEPTH   10'h050
`define RARO_OPC_LOAD_FILE_AND_WORD 10'h300
`define RARO_OPC_LOAD_BANK          10'h048
`define RARO_OPC_STEP_WORD_UP       10'h013
`define RARO_OPC_STEP_WORD_DOWN     10'h017
`define RARO_OPC_LOAD_FROM_RAM      10'h2C0
`define RARO_OPC_SWAP_WITH_RAM      10'h2D0
`define RARO_OPC_SWAP_AND_STEP_DOWN 10'h2F0
`define RARO_OPC_SWAP_AND_STEP_UP   10'h2E0
`define RARO_OPC_STORE_TO_RAM       10'h2B0
`define RARO_OPC_COPY_HIGH_TO_ACC   10'h01E
`define RARO_OPC_COPY_ACC_TO_HIGH   10'h00E
`define RARO_OPC_COPY_WORD_TO_ACC   10'h01F
`define RARO_OPC_COPY_ACC_TO_WORD   10'h00C
`define RARO_OPC_PACK_TO_BYTE       10'h01A
`define RARO_OPC_UNPACK_FROM_BYTE   10'h02A
`define RARO_OPC_ACC_TO_DRIVE_INDEX 10'h029
`define RARO_OPC_DRIVE_INDEX_TO_ACC 10'h051
`define RARO_OPC_BANK_TO_ACC        10'h053

// constants of the data path
`define RARO_RST_NIB     4'h0
`define RARO_RST_BANK    2'h0
`define RARO_RST_DRV     3'h0
`define RARO_RST_BYTE    8'h00
`define RARO_STEP        4'h1
`define RARO_WORD_MIN    4'h0
`define RARO_WORD_MAX    4'hF
`define RARO_ZERO_BIT    1'b0
`define RARO_ZERO_2      2'h0

`endif

/* File: logic/raro_pkg.sv */
// raro_pkg: types shared by the decoder, executor and bench
// assumes raro_regs.svh for widths
`default_nettype none
`include "raro_regs.svh"

package raro_pkg;

   typedef enum {
      RARO_OP_NONE,
      RARO_OP_COPY_STACK_DEPTH,
      RARO_OP_LOAD_FILE_AND_WORD,
      RARO_OP_LOAD_BANK,
      RARO_OP_STEP_WORD_UP,
      RARO_OP_STEP_WORD_DOWN,
      RARO_OP_LOAD_FROM_RAM,
      RARO_OP_SWAP_WITH_RAM,
      RARO_OP_SWAP_AND_STEP_DOWN,
      RARO_OP_SWAP_AND_STEP_UP,
      RARO_OP_STORE_TO_RAM,
      RARO_OP_COPY_HIGH_TO_ACC,
      RARO_OP_COPY_ACC_TO_HIGH,
      RARO_OP_COPY_WORD_TO_ACC,
      RARO_OP_COPY_ACC_TO_WORD,
      RARO_OP_PACK_TO_BYTE,
      RARO_OP_UNPACK_FROM_BYTE,
      RARO_OP_ACC_TO_DRIVE_INDEX,
      RARO_OP_DRIVE_INDEX_TO_ACC,
      RARO_OP_BANK_TO_ACC
   } raro_op_t;

   // ram address: bank, file index, word pointer
   typedef struct packed {
      logic [`RARO_BANK_W-1:0] bank;
      logic [`RARO_NIB_W-1:0]  file;
      logic [`RARO_NIB_W-1:0]  word;
   } raro_addr_t;

   // decoded instruction
   typedef struct packed {
      raro_op_t               op;
      logic [`RARO_NIB_W-1:0] imm;
   } raro_dec_t;

   // whole state of the executor
   typedef struct packed {
      logic [`RARO_NIB_W-1:0]  acc;
      logic [`RARO_NIB_W-1:0]  high;
      raro_addr_t              ptr;
      logic [`RARO_BYTE_W-1:0] byte_buf;
      logic [`RARO_DRV_W-1:0]  drive;
      logic                    skip;
      logic                    fw_run;
      logic                    skipped;
      logic                    wr_en;
      raro_addr_t              wr_addr;
      logic [`RARO_NIB_W-1:0]  wr_data;
   } raro_state_t;

endpackage
`default_nettype wire

/* File: logic/raro_decode.sv */
// raro_decode: combinational opcode classifier for this group
// assumes a 10-bit instruction word from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
`include "raro_regs.svh"

module raro_decode
   import raro_pkg::*;
(
   input  wire logic [`RARO_OPC_W-1:0] instr_word,
   output raro_dec_t                   dec
);

   // masked immediate forms first, then the exact codes
   always_comb begin
      dec.imm = instr_word[`RARO_XOR_IMM];
      dec.op  = RARO_OP_NONE;
      if ((instr_word & `RARO_MASK_FW) == `RARO_OPC_LOAD_FILE_AND_WORD)
         dec.op = RARO_OP_LOAD_FILE_AND_WORD;
      else if ((instr_word & `RARO_MASK_BANK) == `RARO_OPC_LOAD_BANK)
         dec.op = RARO_OP_LOAD_BANK;
      else begin
         unique case (instr_word & `RARO_MASK_XOR)
            `RARO_OPC_LOAD_FROM_RAM:      dec.op = RARO_OP_LOAD_FROM_RAM;
            `RARO_OPC_SWAP_WITH_RAM:      dec.op = RARO_OP_SWAP_WITH_RAM;
            `RARO_OPC_SWAP_AND_STEP_DOWN: dec.op = RARO_OP_SWAP_AND_STEP_DOWN;
            `RARO_OPC_SWAP_AND_STEP_UP:   dec.op = RARO_OP_SWAP_AND_STEP_UP;
            `RARO_OPC_STORE_TO_RAM:       dec.op = RARO_OP_STORE_TO_RAM;
            default: begin
               unique case (instr_word)
                  `RARO_OPC_COPY_STACK_DEPTH:
                     dec.op = RARO_OP_COPY_STACK_DEPTH;
                  `RARO_OPC_STEP_WORD_UP:   dec.op = RARO_OP_STEP_WORD_UP;
                  `RARO_OPC_STEP_WORD_DOWN: dec.op = RARO_OP_STEP_WORD_DOWN;
                  `RARO_OPC_COPY_HIGH_TO_ACC:
                     dec.op = RARO_OP_COPY_HIGH_TO_ACC;
                  `RARO_OPC_COPY_ACC_TO_HIGH:
                     dec.op = RARO_OP_COPY_ACC_TO_HIGH;
                  `RARO_OPC_COPY_WORD_TO_ACC:
                     dec.op = RARO_OP_COPY_WORD_TO_ACC;
                  `RARO_OPC_COPY_ACC_TO_WORD:
                     dec.op = RARO_OP_COPY_ACC_TO_WORD;
                  `RARO_OPC_PACK_TO_BYTE:   dec.op = RARO_OP_PACK_TO_BYTE;
                  `RARO_OPC_UNPACK_FROM_BYTE:
                     dec.op = RARO_OP_UNPACK_FROM_BYTE;
                  `RARO_OPC_ACC_TO_DRIVE_INDEX:
                     dec.op = RARO_OP_ACC_TO_DRIVE_INDEX;
                  `RARO_OPC_DRIVE_INDEX_TO_ACC:
                     dec.op = RARO_OP_DRIVE_INDEX_TO_ACC;
                  `RARO_OPC_BANK_TO_ACC:    dec.op = RARO_OP_BANK_TO_ACC;
                  default:                  dec.op = RARO_OP_NONE;
               endcase
            end
         endcase
      end
   end

endmodule
`default_nettype wire

/* File: logic/raro_step.sv */
// raro_step: wrapping up/down step of a counter with wrap detect
// assumes the caller picks direction; purely combinational
`timescale 1ns/1ps
`default_nettype none

module raro_step #(
   parameter int W = 4
) (
   input  wire logic [W-1:0] value,
   input  wire logic         down,
   output logic      [W-1:0] result,
   output logic              wrapped
);

   localparam logic [W-1:0] ONE = W'(1);

   // wraps modulo 2**W; wrapped flags the far end just reached
   always_comb begin
      result  = down ? (value - ONE) : (value + ONE);
      wrapped = down ? (result == {W{1'b1}}) : (result == '0);
   end

endmodule
`default_nettype wire

/* File: logic/raro_exec.sv */
// raro_exec: executes transfer, ram address and ram move instructions
// assumes one instruction per valid cycle from a fetch unit on clk,
// an external nibble ram read combinationally at data_ptr
`timescale 1ns/1ps
`default_nettype none
`include "raro_regs.svh"

// Summary of operation
// - stack depth into acc low, bit3 cleared
// - immediate pair loads file index, word pointer
// - consecutive file-word loads: only first executes
// - two-bit immediate loads bank select
// - word pointer steps up or down, wrapping
// - skip next on wrap to 0 or 15
// - ram nibble to acc, file xor immediate
// - swap acc with ram, file xor immediate
// - swap, xor, then word pointer down
// - swap, xor, then word pointer up
// - acc to ram, file xor immediate
// - high register copied into acc
// - acc copied into high register
// - word pointer copied into acc
// - acc copied into word pointer
// - high and acc packed into byte buffer
// - byte buffer unpacked to high and acc
// - acc low three bits to drive index
// - drive index into acc, bit3 cleared
// - bank select into acc, upper bits cleared
module raro_exec
   import raro_pkg::*;
(
   input  wire logic                    clk,
   input  wire logic                    reset,
   input  wire logic                    ce,
   input  wire logic                    instr_valid,
   input  wire logic [`RARO_OPC_W-1:0]  instr_word,
   input  wire logic [`RARO_DRV_W-1:0]  stack_depth,
   input  wire logic [`RARO_NIB_W-1:0]  ram_rd_data,
   output logic      [`RARO_NIB_W-1:0]  acc,
   output logic      [`RARO_NIB_W-1:0]  high_reg,
   output raro_addr_t                   data_ptr,
   output logic      [`RARO_BYTE_W-1:0] byte_buffer,
   output logic      [`RARO_DRV_W-1:0]  drive_index,
   output logic                         skip_next,
   output logic                         instr_skipped,
   output logic                         ram_wr_en,
   output raro_addr_t                   ram_wr_addr,
   output logic      [`RARO_NIB_W-1:0]  ram_wr_data
);

   localparam raro_state_t RESET_STATE = '{
      acc:      `RARO_RST_NIB,
      high:     `RARO_RST_NIB,
      ptr:      '{`RARO_RST_BANK, `RARO_RST_NIB, `RARO_RST_NIB},
      byte_buf: `RARO_RST_BYTE,
      drive:    `RARO_RST_DRV,
      skip:     1'b0,
      fw_run:   1'b0,
      skipped:  1'b0,
      wr_en:    1'b0,
      wr_addr:  '{`RARO_RST_BANK, `RARO_RST_NIB, `RARO_RST_NIB},
      wr_data:  `RARO_RST_NIB
   };

   raro_state_t             st_reg;
   raro_state_t             st_next;
   raro_dec_t               dec;
   logic [`RARO_NIB_W-1:0]  rd_nib;
   logic [`RARO_NIB_W-1:0]  step_word;
   logic                    step_wrap;
   logic                    step_down;
   logic                    is_fw;
   logic                    drop;
   logic                    exec;

   raro_decode u_decode (
      .instr_word (instr_word),
      .dec        (dec)
   );

   // one stepper serves all four word pointer movers
   assign step_down = (dec.op == RARO_OP_STEP_WORD_DOWN) ||
                      (dec.op == RARO_OP_SWAP_AND_STEP_DOWN);

   raro_step #(.W(`RARO_NIB_W)) u_step (
      .value   (st_reg.ptr.word),
      .down    (step_down),
      .result  (step_word),
      .wrapped (step_wrap)
   );

   // the ram write lands one edge late, so forward it to a read
   // of the same nibble in the very next instruction
   assign rd_nib = (st_reg.wr_en && (st_reg.wr_addr == st_reg.ptr)) ?
                   st_reg.wr_data : ram_rd_data;

   // a pending skip, or a repeated file-word load, drops the word
   assign is_fw = (dec.op == RARO_OP_LOAD_FILE_AND_WORD);
   assign drop  = st_reg.skip || (is_fw && st_reg.fw_run);
   assign exec  = instr_valid && !drop;

   // next state: every instruction finishes in this one cycle
   always_comb begin
      st_next         = st_reg;
      st_next.wr_en   = 1'b0;
      st_next.skipped = 1'b0;
      if (instr_valid) begin
         st_next.skip    = 1'b0;
         st_next.fw_run  = is_fw;
         st_next.skipped = drop;
      end
      if (exec) begin
         unique case (dec.op)
            RARO_OP_COPY_STACK_DEPTH:
               st_next.acc = {`RARO_ZERO_BIT, stack_depth};
            RARO_OP_LOAD_FILE_AND_WORD: begin
               st_next.ptr.file = instr_word[`RARO_FILE_IMM];
               st_next.ptr.word = instr_word[`RARO_WORD_IMM];
            end
            RARO_OP_LOAD_BANK:
               st_next.ptr.bank = instr_word[`RARO_BANK_IMM];
            RARO_OP_STEP_WORD_UP, RARO_OP_STEP_WORD_DOWN: begin
               st_next.ptr.word = step_word;
               st_next.skip     = step_wrap;
            end
            RARO_OP_LOAD_FROM_RAM: begin
               st_next.acc      = rd_nib;
               st_next.ptr.file = st_reg.ptr.file ^ dec.imm;
            end
            RARO_OP_SWAP_WITH_RAM, RARO_OP_SWAP_AND_STEP_DOWN,
            RARO_OP_SWAP_AND_STEP_UP: begin
               st_next.acc      = rd_nib;
               st_next.wr_en    = 1'b1;
               st_next.wr_addr  = st_reg.ptr;
               st_next.wr_data  = st_reg.acc;
               st_next.ptr.file = st_reg.ptr.file ^ dec.imm;
               if (dec.op != RARO_OP_SWAP_WITH_RAM) begin
                  st_next.ptr.word = step_word;
                  st_next.skip     = step_wrap;
               end
            end
            RARO_OP_STORE_TO_RAM: begin
               st_next.wr_en    = 1'b1;
               st_next.wr_addr  = st_reg.ptr;
               st_next.wr_data  = st_reg.acc;
               st_next.ptr.file = st_reg.ptr.file ^ dec.imm;
            end
            RARO_OP_COPY_HIGH_TO_ACC: st_next.acc = st_reg.high;
            RARO_OP_COPY_ACC_TO_HIGH: st_next.high = st_reg.acc;
            RARO_OP_COPY_WORD_TO_ACC:
               st_next.acc = st_reg.ptr.word;
            RARO_OP_COPY_ACC_TO_WORD:
               st_next.ptr.word = st_reg.acc;
            RARO_OP_PACK_TO_BYTE:
               st_next.byte_buf = {st_reg.high, st_reg.acc};
            RARO_OP_UNPACK_FROM_BYTE: begin
               st_next.high = st_reg.byte_buf[`RARO_BYTE_HI];
               st_next.acc  = st_reg.byte_buf[`RARO_BYTE_LO];
            end
            RARO_OP_ACC_TO_DRIVE_INDEX:
               st_next.drive = st_reg.acc[`RARO_ACC_DRV];
            RARO_OP_DRIVE_INDEX_TO_ACC:
               st_next.acc = {`RARO_ZERO_BIT, st_reg.drive};
            RARO_OP_BANK_TO_ACC:
               st_next.acc = {`RARO_ZERO_2, st_reg.ptr.bank};
            RARO_OP_NONE: ; // other groups are handled elsewhere
         endcase
      end
   end

   // single register for all state; ce low freezes everything but reset
   always_ff @(posedge clk) begin
      if (reset)
         st_reg <= RESET_STATE;
      else if (ce)
         st_reg <= st_next;
   end

   // outputs straight from the state register
   assign acc           = st_reg.acc;
   assign high_reg      = st_reg.high;
   assign data_ptr      = st_reg.ptr;
   assign byte_buffer   = st_reg.byte_buf;
   assign drive_index   = st_reg.drive;
   assign skip_next     = st_reg.skip;
   assign instr_skipped = st_reg.skipped;
   assign ram_wr_en     = st_reg.wr_en;
   assign ram_wr_addr   = st_reg.wr_addr;
   assign ram_wr_data   = st_reg.wr_data;

   // checks on the executor; a taken step is one valid, enabled, undropped cycle
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   logic go;
   assign go = ce && exec;

   sequence fw_taken;
      ce && instr_valid && is_fw && !drop;
   endsequence
   sequence fw_again;
      ce && instr_valid && is_fw;
   endsequence

   stack_copy_a: assert property (
      go && dec.op == RARO_OP_COPY_STACK_DEPTH |=>
         acc == {`RARO_ZERO_BIT, $past(stack_depth)})
      else $error("stack depth copy wrong");

   file_word_load_a: assert property (
      go && is_fw |=> data_ptr.file == $past(instr_word[`RARO_FILE_IMM])
         && data_ptr.word == $past(instr_word[`RARO_WORD_IMM]))
      else $error("file and word load wrong");

   load_run_a: assert property (
      fw_taken ##1 fw_again |=> instr_skipped
         && data_ptr == $past(data_ptr))
      else $error("repeated file-word load executed");

   bank_load_a: assert property (
      go && dec.op == RARO_OP_LOAD_BANK |=>
         data_ptr.bank == $past(instr_word[`RARO_BANK_IMM]))
      else $error("bank load wrong");

   step_up_a: assert property (
      go && dec.op == RARO_OP_STEP_WORD_UP |=>
         data_ptr.word == $past(data_ptr.word) + `RARO_STEP
         && skip_next == (data_ptr.word == `RARO_WORD_MIN))
      else $error("step up or its skip wrong");

   step_down_a: assert property (
      go && dec.op == RARO_OP_STEP_WORD_DOWN |=>
         data_ptr.word == $past(data_ptr.word) - `RARO_STEP
         && skip_next == (data_ptr.word == `RARO_WORD_MAX))
      else $error("step down or its skip wrong");

   skip_drop_a: assert property (
      ce && instr_valid && skip_next |=> instr_skipped && !skip_next
         && acc == $past(acc) && data_ptr == $past(data_ptr))
      else $error("skipped word had an effect");

   ram_load_a: assert property (
      go && dec.op == RARO_OP_LOAD_FROM_RAM |=> acc == $past(rd_nib)
         && data_ptr.file == ($past(data_ptr.file) ^ $past(dec.imm)))
      else $error("ram load or xor wrong");

   swap_a: assert property (
      go && (dec.op == RARO_OP_SWAP_WITH_RAM
         || dec.op == RARO_OP_SWAP_AND_STEP_UP
         || dec.op == RARO_OP_SWAP_AND_STEP_DOWN) |=>
         ram_wr_en && ram_wr_data == $past(acc) && acc == $past(rd_nib)
         && ram_wr_addr == $past(data_ptr))
      else $error("swap with ram wrong");

   store_a: assert property (
      go && dec.op == RARO_OP_STORE_TO_RAM |=> ram_wr_en
         && ram_wr_data == $past(acc) && acc == $past(acc)
         && data_ptr.file == ($past(data_ptr.file) ^ $past(dec.imm)))
      else $error("store to ram wrong");

   byte_pack_a: assert property (
      go && dec.op == RARO_OP_PACK_TO_BYTE |=>
         byte_buffer == {$past(high_reg), $past(acc)})
      else $error("byte pack wrong");

   bank_acc_a: assert property (
      go && dec.op == RARO_OP_BANK_TO_ACC |=>
         acc == {`RARO_ZERO_2, $past(data_ptr.bank)})
      else $error("bank to acc wrong");

endmodule
`default_nettype wire

/* File: sim/tb.sv */
// tb: self-checking bench for raro_exec, a scoreboard queue fed by the driver
// assumes raro_pkg is compiled first and raro_regs.svh is on the include path
`timescale 1ns/1ps
`default_nettype none
`include "raro_regs.svh"

module tb
   import raro_pkg::*;
();
   logic                    clk;
   logic                    reset;
   logic                    ce;
   logic                    instr_valid;
   logic [`RARO_OPC_W-1:0]  instr_word;
   logic [`RARO_DRV_W-1:0]  stack_depth;
   logic [`RARO_NIB_W-1:0]  ram_rd_data;
   logic [`RARO_NIB_W-1:0]  acc;
   logic [`RARO_NIB_W-1:0]  high_reg;
   raro_addr_t              data_ptr;
   logic [`RARO_BYTE_W-1:0] byte_buffer;
   logic [`RARO_DRV_W-1:0]  drive_index;
   logic                    skip_next;
   logic                    instr_skipped;
   logic                    ram_wr_en;
   raro_addr_t              ram_wr_addr;
   logic [`RARO_NIB_W-1:0]  ram_wr_data;
   logic [`RARO_NIB_W-1:0]  ram [1024];
   logic [`RARO_NIB_W-1:0]  mram [1024];
   logic [`RARO_OPC_W-1:0]  opc [19];
   logic [10:0]             dseq [];
   raro_state_t             m;
   raro_state_t             expq [$];
   int                      failures = 0;
   int                      checks = 0;

   raro_exec DUT (
      .clk           (clk),
      .reset         (reset),
      .ce            (ce),
      .instr_valid   (instr_valid),
      .instr_word    (instr_word),
      .stack_depth   (stack_depth),
      .ram_rd_data   (ram_rd_data),
      .acc           (acc),
      .high_reg      (high_reg),
      .data_ptr      (data_ptr),
      .byte_buffer   (byte_buffer),
      .drive_index   (drive_index),
      .skip_next     (skip_next),
      .instr_skipped (instr_skipped),
      .ram_wr_en     (ram_wr_en),
      .ram_wr_addr   (ram_wr_addr),
      .ram_wr_data   (ram_wr_data)
   );

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // nibble ram: combinational read, write only on an enabled edge
   assign ram_rd_data = ram[data_ptr];
   always @(posedge clk) begin
      if (ce && ram_wr_en)
         ram[ram_wr_addr] <= ram_wr_data;
   end

   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   task automatic end_of_test();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // opcode class masks: immediates are don't-care bits
   function automatic logic [9:0] msk(input int k);
      if (k == 1) return `RARO_MASK_FW;
      if (k == 2) return `RARO_MASK_BANK;
      if (k >= 5 && k <= 9) return `RARO_MASK_XOR;
      return `RARO_MASK_FULL;
   endfunction

   function automatic int dec(input logic [9:0] w);
      for (int i = 0; i < 19; i++) begin
         if ((w & msk(i)) == opc[i]) return i;
      end
      return 19;
   endfunction

   // random code of the group, or an unknown code now and then
   function automatic logic [9:0] rnd();
      int k = $urandom % 20;
      if (k == 19) return 10'h000;
      return opc[k] | (10'($urandom) & ~msk(k));
   endfunction

   task automatic stepw(input bit up);
      m.ptr.word = up ? m.ptr.word + `RARO_STEP : m.ptr.word - `RARO_STEP;
      m.skip = (m.ptr.word == (up ? `RARO_WORD_MIN : `RARO_WORD_MAX));
   endtask

   // reference model; ram model updated at once, so forwarding is implied
   task automatic model(input logic [9:0] w);
      int k = dec(w);
      logic [3:0] j = w[3:0];
      logic [3:0] old = m.acc;
      raro_state_t e;
      m.skipped = m.skip || (m.fw_run && k == 1);
      m.fw_run = (k == 1);
      m.skip = 1'b0;
      m.wr_en = 1'b0;
      if (!m.skipped) begin
         case (k)
            0: m.acc = {1'b0, stack_depth};
            1: m.ptr[7:0] = w[7:0];
            2: m.ptr.bank = w[1:0];
            3, 4: stepw(k == 3);
            5: begin
               m.acc = mram[m.ptr];
               m.ptr.file ^= j;
            end
            6, 7, 8, 9: begin
               m.wr_en = 1'b1;
               m.wr_addr = m.ptr;
               m.wr_data = old;
               if (k != 9) m.acc = mram[m.ptr];
               mram[m.ptr] = old;
               m.ptr.file ^= j;
               if (k == 7 || k == 8) stepw(k == 8);
            end
            10: m.acc = m.high;
            11: m.high = m.acc;
            12: m.acc = m.ptr.word;
            13: m.ptr.word = m.acc;
            14: m.byte_buf = {m.high, m.acc};
            15: {m.high, m.acc} = m.byte_buf;
            16: m.drive = m.acc[2:0];
            17: m.acc = {1'b0, m.drive};
            18: m.acc = {2'h0, m.ptr.bank};
            default: ;
         endcase
      end
      e = m;
      e.fw_run = 1'b0;
      expq.push_back(e);
   endtask

   // drive one cycle at the falling edge; note expectation if it is taken
   task automatic issue(input logic [9:0] w, input bit v = 1, input bit c = 1);
      @(negedge clk);
      instr_word = w;
      instr_valid = v;
      ce = c;
      stack_depth = 3'($urandom);
      if (c && v && !reset) model(w);
   endtask

   task automatic hold_reset(input int n);
      @(negedge clk);
      reset = 1'b1;
      // drop valid, or the release edge takes a word with no note queued
      instr_valid = 1'b0;
      m = '0;
      repeat (n) @(negedge clk);
      chk(64'({acc, high_reg, data_ptr, byte_buffer, drive_index, skip_next,
               instr_skipped, ram_wr_en, ram_wr_addr, ram_wr_data}), 64'h0);
      reset = 1'b0;
   endtask

   // watcher: every taken word shows its result one edge later
   initial begin
      raro_state_t e;
      bit tk;
      forever begin
         @(posedge clk);
         tk = ce && instr_valid && !reset;
         #1;
         if (tk) begin
            e = expq.pop_front();
            chk(64'(acc), 64'(e.acc));
            chk(64'(high_reg), 64'(e.high));
            chk(64'(data_ptr), 64'(e.ptr));
            chk(64'(byte_buffer), 64'(e.byte_buf));
            chk(64'(drive_index), 64'(e.drive));
            chk(64'({skip_next, instr_skipped}), 64'({e.skip, e.skipped}));
            chk(64'(ram_wr_en), 64'(e.wr_en));
            if (e.wr_en)
               chk(64'({ram_wr_addr, ram_wr_data}),
                   64'({e.wr_addr, e.wr_data}));
         end
      end
   end

   initial begin
      #50us;
      failures++;
      end_of_test();
   end

   initial begin
      reset = 1'b1;
      ce = 1'b0;
      instr_valid = 1'b0;
      instr_word = 10'h000;
      stack_depth = 3'h0;
      m = '0;
      void'($urandom(30));
      for (int i = 0; i < 1024; i++) begin
         ram[i] = 4'($urandom);
         mram[i] = ram[i];
      end
      opc = '{`RARO_OPC_COPY_STACK_DEPTH, `RARO_OPC_LOAD_FILE_AND_WORD,
              `RARO_OPC_LOAD_BANK, `RARO_OPC_STEP_WORD_UP,
              `RARO_OPC_STEP_WORD_DOWN, `RARO_OPC_LOAD_FROM_RAM,
              `RARO_OPC_SWAP_WITH_RAM, `RARO_OPC_SWAP_AND_STEP_DOWN,
              `RARO_OPC_SWAP_AND_STEP_UP, `RARO_OPC_STORE_TO_RAM,
              `RARO_OPC_COPY_HIGH_TO_ACC, `RARO_OPC_COPY_ACC_TO_HIGH,
              `RARO_OPC_COPY_WORD_TO_ACC, `RARO_OPC_COPY_ACC_TO_WORD,
              `RARO_OPC_PACK_TO_BYTE, `RARO_OPC_UNPACK_FROM_BYTE,
              `RARO_OPC_ACC_TO_DRIVE_INDEX, `RARO_OPC_DRIVE_INDEX_TO_ACC,
              `RARO_OPC_BANK_TO_ACC};
      hold_reset(6);
      // every code once with random immediates
      for (int k = 0; k < 19; k++) begin
         issue(opc[k] | (10'($urandom) & ~msk(k)));
      end
      // bit 10 = valid: load runs across a gap, wraps of up and down steps,
      // bank loads read back into acc, skip landing on a load
      dseq = '{11'h7A5, 11'h712, 11'h000, 11'h756, 11'h41F, 11'h70F,
               11'h413, 11'h40E, 11'h700, 11'h417, 11'h6E0, 11'h700,
               11'h6F5, 11'h6B0, 11'h70F, 11'h6E7, 11'h41F, 11'h6B0,
               11'h6C0, 11'h6D0, 11'h6D0, 11'h70F, 11'h413, 11'h7AB,
               11'h7CD, 11'h41F, 11'h44B, 11'h453, 11'h448, 11'h453};
      foreach (dseq[i]) begin
         issue(dseq[i][9:0], dseq[i][10]);
      end
      // random stream with idle and frozen cycles
      for (int n = 0; n < 400; n++) begin
         issue(rnd(), ($urandom % 4) != 0, ($urandom % 8) != 0);
      end
      // flush a pending write, then reset in mid-run
      issue(10'h000);
      hold_reset(2);
      for (int n = 0; n < 100; n++) begin
         issue(rnd(), ($urandom % 4) != 0, ($urandom % 8) != 0);
      end
      issue(10'h000, 0);
      repeat (2) @(posedge clk);
      #2;
      end_of_test();
   end
endmodule

`default_nettype wire
